// File: src/cglg_logic_block.sv
`timescale 1ns/1ps
`default_nettype none
`include "cglg_defines.svh"

// Notes on behaviour
// (RQ1) function setting picks equal, not-equal, or, nor or latch
// (RQ2) equal: true when all connected inputs agree, else false
// (RQ3) not-equal: true when connected inputs disagree, false when all agree
// (RQ4) or: true if any input true, false only if all false
// (RQ5) nor: true only when all inputs false
// (RQ6) true is logic 1 (fully on), false is logic 0 (fully off)
// (RQ7) latch: output tracks data while freeze is low
// (RQ8) latch: freeze rising captures data, output held while freeze high
// (RQ9) data rising during freeze leaves output false until freeze drops
// (RQ10) freeze rising on true data keeps output true while frozen
// (RQ11) undecidable result takes value and error from error-handling setting
// (RQ12) error-handling offers true/false with error set or clear
// (RQ13) gate input errors ignored when valid inputs fix the output
// (RQ14) latch unfrozen without error: value and error follow data
// (RQ15) frozen output keeps captured error; freeze error means follow data
// (RQ16) up to eight inputs with connected flags; output registered each clock
// (RQ17) synchronous reset clears output value, error and latch state
module cglg_logic_block
  import cglg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration
  input wire cglg_func_t functionSel,
  input wire cglg_err_mode_t errorMode,
  // gate inputs
  input wire cglg_sig_t [`CGLG_NUM_INPUTS-1:0] gateIn,
  input wire logic [`CGLG_NUM_INPUTS-1:0] connected,
  // latch inputs
  input wire cglg_sig_t latchData,
  input wire cglg_sig_t freeze,
  // result
  output cglg_sig_t result
);

  logic [`CGLG_NUM_INPUTS-1:0] goodTrue;
  logic [`CGLG_NUM_INPUTS-1:0] goodFalse;
  logic [`CGLG_NUM_INPUTS-1:0] anyErr;
  logic [`CGLG_NUM_INPUTS-1:0] used;

  // per-input classification, unconnected inputs drop out
  genvar gi;
  generate
    for (gi = 0; gi < `CGLG_NUM_INPUTS; gi++) begin : g_class
      assign used[gi] = connected[gi]; // RQ16
      assign goodTrue[gi] = connected[gi] & ~gateIn[gi].error & gateIn[gi].value;
      assign goodFalse[gi] = connected[gi] & ~gateIn[gi].error & ~gateIn[gi].value;
      assign anyErr[gi] = connected[gi] & gateIn[gi].error;
    end
  endgenerate

  logic hasTrue;
  logic hasFalse;
  logic hasErr;
  assign hasTrue = |goodTrue;
  assign hasFalse = |goodFalse;
  assign hasErr = |anyErr;

  cglg_sig_t ehResult;
  always_comb begin
    unique case (errorMode) // RQ12
      CGLG_EH_TRUE_GOOD: ehResult = '{value: 1'h1, error: 1'h0};
      CGLG_EH_TRUE_BAD: ehResult = '{value: 1'h1, error: 1'h1};
      CGLG_EH_FALSE_GOOD: ehResult = '{value: 1'h0, error: 1'h0};
      CGLG_EH_FALSE_BAD: ehResult = '{value: 1'h0, error: 1'h1};
    endcase
  end

  // gate evaluation; a mix of good true and false decides equality even with errors
  cglg_sig_t gateResult;
  always_comb begin
    gateResult = '{value: 1'h0, error: 1'h0};
    unique case (functionSel) // RQ1
      CGLG_FN_EQUAL, CGLG_FN_NOT_EQUAL: begin
        if (hasTrue && hasFalse) begin
          gateResult.value = (functionSel == CGLG_FN_NOT_EQUAL); // RQ2 RQ3 RQ13
        end else if (hasErr) begin
          gateResult = ehResult; // RQ11
        end else begin
          gateResult.value = (functionSel == CGLG_FN_EQUAL); // RQ2 RQ3 RQ6
        end
      end
      CGLG_FN_OR, CGLG_FN_NOR: begin
        if (hasTrue) begin
          gateResult.value = (functionSel == CGLG_FN_OR); // RQ4 RQ5 RQ13
        end else if (hasErr) begin
          gateResult = ehResult; // RQ11
        end else begin
          gateResult.value = (functionSel == CGLG_FN_NOR); // RQ4 RQ5 RQ6
        end
      end
      default: gateResult = '{value: 1'h0, error: 1'h0};
    endcase
  end

  // result lags the inputs by one edge, hence |=> throughout
  property p_eq_agree;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_EQUAL && !hasErr && !(hasTrue && hasFalse))
        |=> result.value && !result.error;
  endproperty
  a_eq_agree: assert property (p_eq_agree) else $error("equal false on agreeing inputs"); // RQ2

  property p_neq_mix;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_NOT_EQUAL && hasTrue && hasFalse)
        |=> result.value && !result.error;
  endproperty
  a_neq_mix: assert property (p_neq_mix) else $error("not-equal false on mixed inputs"); // RQ3

  property p_mix_err_ignored;
    @(posedge clock) disable iff (!rst_b)
      (functionSel inside {CGLG_FN_EQUAL, CGLG_FN_NOT_EQUAL} && hasTrue && hasFalse && hasErr)
        |=> !result.error;
  endproperty
  a_mix_err_ignored: assert property (p_mix_err_ignored) else $error("decided result carried an error"); // RQ13

  property p_or_false;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_OR && !hasTrue && !hasErr)
        |=> !result.value && !result.error;
  endproperty
  a_or_false: assert property (p_or_false) else $error("or true with all inputs false"); // RQ4

  property p_nor_true;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_NOR && !hasTrue && !hasErr)
        |=> result.value && !result.error;
  endproperty
  a_nor_true: assert property (p_nor_true) else $error("nor false with all inputs false"); // RQ5

  property p_eq_undecided;
    @(posedge clock) disable iff (!rst_b)
      (functionSel inside {CGLG_FN_EQUAL, CGLG_FN_NOT_EQUAL} && hasErr && !(hasTrue && hasFalse))
        |=> result == $past(ehResult);
  endproperty
  a_eq_undecided: assert property (p_eq_undecided) else $error("equality ignored error handling"); // RQ11

  property p_nor_undecided;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_NOR && !hasTrue && hasErr)
        |=> result == $past(ehResult);
  endproperty
  a_nor_undecided: assert property (p_nor_undecided) else $error("nor ignored error handling"); // RQ11

  property p_eh_value;
    @(posedge clock) disable iff (!rst_b)
      (functionSel inside {CGLG_FN_OR, CGLG_FN_NOR} && !hasTrue && hasErr)
        |=> result.value == ($past(errorMode) == CGLG_EH_TRUE_GOOD || $past(errorMode) == CGLG_EH_TRUE_BAD);
  endproperty
  a_eh_value: assert property (p_eh_value) else $error("error handling value wrong"); // RQ12

  property p_eh_error;
    @(posedge clock) disable iff (!rst_b)
      (functionSel inside {CGLG_FN_OR, CGLG_FN_NOR} && !hasTrue && hasErr)
        |=> result.error == ($past(errorMode) == CGLG_EH_TRUE_BAD || $past(errorMode) == CGLG_EH_FALSE_BAD);
  endproperty
  a_eh_error: assert property (p_eh_error) else $error("error handling status wrong"); // RQ12

  // latch state: captured copy of data taken on the freeze edge
  cglg_sig_t held;
  cglg_sig_t next_held;
  logic frozen;
  logic next_frozen;
  logic freezeOn;
  assign freezeOn = freeze.value & ~freeze.error;

  always_comb begin
    next_held = held;
    next_frozen = freezeOn;
    if (!freezeOn || !frozen) begin
      next_held = latchData; // RQ8 RQ10
    end
  end

  cglg_sig_t latchResult;
  always_comb begin
    // freeze error means follow data, not hold
    if (freezeOn && frozen) begin
      latchResult = held; // RQ8 RQ9 RQ15
    end else begin
      latchResult = latchData; // RQ7 RQ14 RQ15
    end
  end

  // first edge with freeze on passes data through and captures it
  property p_latch_capture;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && freezeOn && !frozen)
        |=> result == $past(latchData);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("latch missed the captured data"); // RQ8

  property p_latch_steady;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && $past(functionSel) == CGLG_FN_LATCH && freezeOn && frozen)
        |=> $stable(result);
  endproperty
  a_latch_steady: assert property (p_latch_steady) else $error("held output changed"); // RQ8

  property p_latch_late_data;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && $past(functionSel) == CGLG_FN_LATCH && freezeOn && frozen && !result.value)
        |=> !result.value;
  endproperty
  a_latch_late_data: assert property (p_latch_late_data) else $error("held false output rose"); // RQ9

  property p_latch_keep_true;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && $past(functionSel) == CGLG_FN_LATCH && freezeOn && frozen && result.value)
        |=> result.value;
  endproperty
  a_latch_keep_true: assert property (p_latch_keep_true) else $error("held true output fell"); // RQ10

  property p_freeze_fault;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && freeze.error)
        |=> result == $past(latchData);
  endproperty
  a_freeze_fault: assert property (p_freeze_fault) else $error("faulty freeze did not follow data"); // RQ15

  property p_latch_error_follow;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && !freeze.value && !freeze.error)
        |=> result.error == $past(latchData.error);
  endproperty
  a_latch_error_follow: assert property (p_latch_error_follow) else $error("latch error did not follow"); // RQ14

  cglg_sig_t next_result;
  always_comb begin
    next_result = (functionSel == CGLG_FN_LATCH) ? latchResult : gateResult; // RQ1
  end

  // reset is synchronous; rst_b low for one edge clears everything
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      result <= '{value: `CGLG_RESET_VALUE, error: `CGLG_RESET_ERROR}; // RQ17
      held <= '{value: `CGLG_RESET_VALUE, error: `CGLG_RESET_ERROR}; // RQ17
      frozen <= 1'h0;
    end else begin
      result <= next_result; // RQ16
      held <= next_held;
      frozen <= next_frozen;
    end
  end

  // a freeze edge on false data and later true data keeps output false
  property p_latch_hold;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && freezeOn && $past(freezeOn) && frozen)
        |=> result == $past(held);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch did not hold"); // RQ8

  property p_latch_follow;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_LATCH && !freezeOn) |=> result == $past(latchData);
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("latch did not follow data"); // RQ7

  property p_or_true;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_OR && hasTrue) |=> result.value && !result.error;
  endproperty
  a_or_true: assert property (p_or_true) else $error("or missed a true input"); // RQ4

  property p_nor_false;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_NOR && hasTrue) |=> !result.value && !result.error;
  endproperty
  a_nor_false: assert property (p_nor_false) else $error("nor not false on true input"); // RQ5

  property p_eq_mix;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_EQUAL && hasTrue && hasFalse) |=> !result.value;
  endproperty
  a_eq_mix: assert property (p_eq_mix) else $error("equal true on mixed inputs"); // RQ2

  property p_neq_same;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_NOT_EQUAL && !hasErr && (hasTrue ^ hasFalse)) |=> !result.value;
  endproperty
  a_neq_same: assert property (p_neq_same) else $error("not-equal true on agreeing inputs"); // RQ3

  property p_err_mode;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_OR && !hasTrue && hasErr) |=> result == $past(ehResult);
  endproperty
  a_err_mode: assert property (p_err_mode) else $error("error handling not applied"); // RQ11

  property p_reset_clear;
    @(posedge clock) !rst_b |=> !result.value && !result.error && !frozen;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear state"); // RQ17

  property p_unconnected;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_NOR && used == '0) |=> result.value && !result.error;
  endproperty
  a_unconnected: assert property (p_unconnected) else $error("unconnected inputs were counted"); // RQ16

  property p_or_unconnected;
    @(posedge clock) disable iff (!rst_b)
      (functionSel == CGLG_FN_OR && used == '0)
        |=> !result.value && !result.error;
  endproperty
  a_or_unconnected: assert property (p_or_unconnected) else $error("or true with nothing connected"); // RQ16

  // codes outside the five functions must not leak a stale result
  property p_bad_function;
    @(posedge clock) disable iff (!rst_b)
      !(functionSel inside {CGLG_FN_EQUAL, CGLG_FN_NOT_EQUAL, CGLG_FN_OR, CGLG_FN_NOR, CGLG_FN_LATCH})
        |=> !result.value && !result.error;
  endproperty
  a_bad_function: assert property (p_bad_function) else $error("unknown function gave a result"); // RQ1

  property p_reset_held;
    @(posedge clock)
      !rst_b |=> !held.value && !held.error;
  endproperty
  a_reset_held: assert property (p_reset_held) else $error("reset did not clear captured data"); // RQ17

endmodule

`default_nettype wire

// File: src/cglg_defines.svh
`ifndef CGLG_DEFINES_SVH
`define CGLG_DEFINES_SVH

`define CGLG_NUM_INPUTS 8
`define CGLG_RESET_VALUE 1'h0
`define CGLG_RESET_ERROR 1'h0

`endif

// File: src/cglg_pkg.sv
package cglg_pkg;

  typedef enum logic [2:0] {
    CGLG_FN_EQUAL,
    CGLG_FN_NOT_EQUAL,
    CGLG_FN_OR,
    CGLG_FN_NOR,
    CGLG_FN_LATCH
  } cglg_func_t;

  typedef enum logic [1:0] {
    CGLG_EH_TRUE_GOOD,
    CGLG_EH_TRUE_BAD,
    CGLG_EH_FALSE_GOOD,
    CGLG_EH_FALSE_BAD
  } cglg_err_mode_t;

  typedef struct packed {
    logic value;
    logic error;
  } cglg_sig_t;

endpackage

// File: tb/cglg_source.sv
`timescale 1ns/1ps
`default_nettype none
`include "cglg_defines.svh"
module cglg_source
  import cglg_pkg::*;
(
  // levels and faults from the neighbouring blocks
  input wire logic [`CGLG_NUM_INPUTS-1:0] levels,
  input wire logic [`CGLG_NUM_INPUTS-1:0] faults,
  // toward the block
  output var cglg_sig_t [`CGLG_NUM_INPUTS-1:0] gateIn
);
  // neighbours present plain levels, so no handshake is modelled
  always_comb begin
    for (int i = 0; i < `CGLG_NUM_INPUTS; i++) begin
      gateIn[i] = '{value: levels[i], error: faults[i]};
    end
  end
endmodule
`default_nettype wire

// File: tb/cglg_logic_block_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cglg_logic_block_tb;
  import cglg_pkg::*;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [2:0] fnSel = CGLG_FN_OR;
  logic [1:0] mode = CGLG_EH_FALSE_BAD;
  logic [7:0] levels = 8'h01;
  logic [7:0] faults = 8'h00;
  logic [7:0] conn = 8'hFF;
  cglg_sig_t dataIn = 2'h0;
  cglg_sig_t freezeIn = 2'h0;
  wire cglg_sig_t [7:0] gateIn;
  wire cglg_sig_t result;
  int errTotal = 0;
  int nChecks = 0;
  // fn, mode, levels, faults, connected, expected value and error
  logic [30:0] rows [21] = '{
    {CGLG_FN_EQUAL, CGLG_EH_FALSE_BAD, 8'h00, 8'h00, 8'h07, 2'h2},
    {CGLG_FN_EQUAL, CGLG_EH_FALSE_BAD, 8'h05, 8'h00, 8'h07, 2'h0},
    {CGLG_FN_EQUAL, CGLG_EH_FALSE_BAD, 8'hFF, 8'h00, 8'hFF, 2'h2},
    {CGLG_FN_EQUAL, CGLG_EH_FALSE_BAD, 8'h01, 8'h00, 8'h06, 2'h2},
    {CGLG_FN_NOT_EQUAL, CGLG_EH_FALSE_BAD, 8'h80, 8'h00, 8'hFF, 2'h2},
    {CGLG_FN_NOT_EQUAL, CGLG_EH_TRUE_BAD, 8'h00, 8'h00, 8'hFF, 2'h0},
    {CGLG_FN_OR, CGLG_EH_FALSE_BAD, 8'h80, 8'h00, 8'hFF, 2'h2},
    {CGLG_FN_OR, CGLG_EH_TRUE_BAD, 8'h00, 8'h00, 8'hFF, 2'h0},
    {CGLG_FN_NOR, CGLG_EH_FALSE_BAD, 8'h00, 8'h00, 8'hFF, 2'h2},
    {CGLG_FN_NOR, CGLG_EH_TRUE_BAD, 8'h40, 8'h00, 8'hFF, 2'h0},
    {CGLG_FN_EQUAL, CGLG_EH_TRUE_BAD, 8'h01, 8'h04, 8'h07, 2'h0},
    {CGLG_FN_OR, CGLG_EH_FALSE_BAD, 8'h01, 8'h02, 8'h03, 2'h2},
    {CGLG_FN_OR, CGLG_EH_TRUE_GOOD, 8'h00, 8'h02, 8'h03, 2'h2},
    {CGLG_FN_OR, CGLG_EH_TRUE_BAD, 8'h00, 8'h02, 8'h03, 2'h3},
    {CGLG_FN_NOR, CGLG_EH_FALSE_GOOD, 8'h00, 8'h02, 8'h03, 2'h0},
    {CGLG_FN_NOR, CGLG_EH_FALSE_BAD, 8'h00, 8'h02, 8'h03, 2'h1},
    {CGLG_FN_EQUAL, CGLG_EH_TRUE_BAD, 8'h00, 8'h02, 8'h03, 2'h3},
    {CGLG_FN_NOT_EQUAL, CGLG_EH_FALSE_BAD, 8'h03, 8'h01, 8'h03, 2'h1},
    {CGLG_FN_NOR, CGLG_EH_TRUE_BAD, 8'hFF, 8'hFF, 8'h00, 2'h2},
    {CGLG_FN_OR, CGLG_EH_TRUE_BAD, 8'hFF, 8'hFF, 8'h00, 2'h0},
    {3'h7, CGLG_EH_TRUE_BAD, 8'hFF, 8'h00, 8'hFF, 2'h0}
  };

  cglg_source source (.levels(levels), .faults(faults), .gateIn(gateIn));

  cglg_logic_block uut (
    .clock(clock),
    .rst_b(rst_b),
    .functionSel(cglg_func_t'(fnSel)),
    .errorMode(cglg_err_mode_t'(mode)),
    .gateIn(gateIn),
    .connected(conn),
    .latchData(dataIn),
    .freeze(freezeIn),
    .result(result)
  );

  always #5 clock = ~clock;

  task automatic report_and_stop();
    if (errTotal == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ev, input logic ee);
    nChecks++;
    if (result.value !== ev || result.error !== ee) begin
      errTotal++;
      $display("MISMATCH t=%0t result=%b%b expected=%b%b", $time, result.value, result.error, ev, ee);
    end
  endtask

  // data value/error then freeze value/error, checked one edge later
  task automatic lstep(input logic [3:0] dfz, input logic [1:0] exp);
    dataIn = cglg_sig_t'(dfz[3:2]);
    freezeIn = cglg_sig_t'(dfz[1:0]);
    @(negedge clock);
    chk(exp[1], exp[0]);
  endtask

  initial begin
    repeat (8) @(negedge clock);
    chk(1'h0, 1'h0);
    rst_b = 1'h1;
    @(negedge clock);
    chk(1'h1, 1'h0);
    foreach (rows[i]) begin
      {fnSel, mode, levels, faults, conn} = rows[i][30:2];
      @(negedge clock);
      chk(rows[i][1], rows[i][0]);
    end
    fnSel = CGLG_FN_LATCH;
    lstep(4'h8, 2'h2);
    lstep(4'hA, 2'h2);
    lstep(4'h2, 2'h2);
    lstep(4'h0, 2'h0);
    lstep(4'h2, 2'h0);
    lstep(4'hA, 2'h0);
    lstep(4'h8, 2'h2);
    lstep(4'h4, 2'h1);
    lstep(4'h6, 2'h1);
    lstep(4'hA, 2'h1);
    lstep(4'hB, 2'h2);
    // reset in mid-run must override a true result
    {fnSel, levels, faults, conn} = {CGLG_FN_OR, 8'h01, 8'h00, 8'h01};
    rst_b = 1'h0;
    @(negedge clock);
    chk(1'h0, 1'h0);
    rst_b = 1'h1;
    @(negedge clock);
    chk(1'h1, 1'h0);
    report_and_stop();
  end

  // about 45 cycles are needed; allow a wide margin
  initial begin
    #3000;
    errTotal++;
    report_and_stop();
  end
endmodule
`default_nettype wire
